// File: hdl/frcct_pkg.sv
// frcct_pkg: register addresses, field positions, reset values and types
// for the free-running capture/compare timer.
// assumes a byte-wide cpu register port clocked by mclk (100 MHz).
package frcct_pkg;

    // byte addresses on the cpu register port
    localparam logic [15:0] FRCCT_ADDR_CNT_LO  = 16'hff12;
    localparam logic [15:0] FRCCT_ADDR_CNT_HI  = 16'hff13;
    localparam logic [15:0] FRCCT_ADDR_CAP_LO  = 16'hff14;
    localparam logic [15:0] FRCCT_ADDR_CAP_HI  = 16'hff15;
    localparam logic [15:0] FRCCT_ADDR_CMP_LO  = 16'hff16;
    localparam logic [15:0] FRCCT_ADDR_CMP_HI  = 16'hff17;
    localparam logic [15:0] FRCCT_ADDR_MODE    = 16'hff48;

    // timer_mode_control fields
    localparam int          FRCCT_MODE_CKS_LSB = 1;
    localparam int          FRCCT_MODE_EDG_LSB = 4;
    localparam int          FRCCT_MODE_OVF_BIT = 6;

    // reset values and the counter maximum
    localparam logic [15:0] FRCCT_CNT_RST      = 16'h0000;
    localparam logic [15:0] FRCCT_CMP_RST      = 16'hffff;
    localparam logic [15:0] FRCCT_CNT_MAX      = 16'hffff;
    localparam logic [7:0]  FRCCT_RDATA_NONE   = 8'h00;

    // count clock select: period of 2, 4, 16 or 256 mclk cycles
    localparam logic [1:0]  FRCCT_CKS_DIV2     = 2'b00;
    localparam logic [1:0]  FRCCT_CKS_DIV4     = 2'b01;
    localparam logic [1:0]  FRCCT_CKS_DIV16    = 2'b10;
    localparam logic [1:0]  FRCCT_CKS_DIV256   = 2'b11;
    localparam logic [7:0]  FRCCT_MASK_DIV2    = 8'h01;
    localparam logic [7:0]  FRCCT_MASK_DIV4    = 8'h03;
    localparam logic [7:0]  FRCCT_MASK_DIV16   = 8'h0f;
    localparam logic [7:0]  FRCCT_MASK_DIV256  = 8'hff;
    localparam logic [7:0]  FRCCT_HALF_DIV2    = 8'h01;
    localparam logic [7:0]  FRCCT_HALF_DIV4    = 8'h02;
    localparam logic [7:0]  FRCCT_HALF_DIV16   = 8'h08;
    localparam logic [7:0]  FRCCT_HALF_DIV256  = 8'h80;

    // capture edge select
    typedef enum logic [1:0] {
        FRCCT_EDGE_OFF  = 2'b00,
        FRCCT_EDGE_RISE = 2'b01,
        FRCCT_EDGE_FALL = 2'b10,
        FRCCT_EDGE_BOTH = 2'b11
    } frcct_edge_t;

    // one cpu bus cycle request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } frcct_bus_req_t;

    // entire state of the timer
    typedef struct packed {
        logic [7:0]  presc;
        logic [15:0] count;
        logic [15:0] rbuf;
        logic        frozen;
        logic [15:0] cmp;
        logic [15:0] cap;
        logic [1:0]  cks;
        frcct_edge_t edg;
        logic        ovf;
        logic        trig_prev;
        logic        irq;
        logic [7:0]  irq_cnt;
        logic [7:0]  rdata;
    } frcct_state_t;

endpackage : frcct_pkg

// File: hdl/frcct_top.sv
// frcct_top: 16-bit free-running counter with compare interrupt, pin capture
// and a freezing read buffer for byte-pair counter reads.
// assumes the cpu port is synchronous to mclk, one access per strobe cycle.
//
// How it works
// - free 16-bit count, irq on every compare match
// - match never clears or reloads the counter
// - count clock period 2, 4, 16, 256 mclk
// - edge select: off, rising, falling, both
// - capture loads count, holds until next edge
// - low-byte read freezes the read buffer
// - high-byte read releases the frozen buffer
// - counter bytes read low then high, paired
// - reset clears counter, then free-running resumes
// - counter keeps running through stabilisation waits
// - compare rewrite may double one interval
// - irq output stays high half count period
// - compare bytes at ff17 high, ff16 low
// - reset loads compare with all ones
// - overflow flag on wrap, software or reset clears
`timescale 1ns/1ps

module frcct_top
(
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire frcct_pkg::frcct_bus_req_t bus_req,
    output logic [7:0]                     bus_rdata,
    input  wire logic                      capture_trigger_pin,
    output logic                           compare_match_irq
);
    import frcct_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // prescaler mask whose all-ones pattern marks a count clock tick
    function automatic logic [7:0] frcct_mask(input logic [1:0] cks);
        case (cks)
            FRCCT_CKS_DIV2:  frcct_mask = FRCCT_MASK_DIV2;
            FRCCT_CKS_DIV4:  frcct_mask = FRCCT_MASK_DIV4;
            FRCCT_CKS_DIV16: frcct_mask = FRCCT_MASK_DIV16;
            default:         frcct_mask = FRCCT_MASK_DIV256;
        endcase
    endfunction : frcct_mask

    // half a count clock period in mclk cycles
    function automatic logic [7:0] frcct_half(input logic [1:0] cks);
        case (cks)
            FRCCT_CKS_DIV2:  frcct_half = FRCCT_HALF_DIV2;
            FRCCT_CKS_DIV4:  frcct_half = FRCCT_HALF_DIV4;
            FRCCT_CKS_DIV16: frcct_half = FRCCT_HALF_DIV16;
            default:         frcct_half = FRCCT_HALF_DIV256;
        endcase
    endfunction : frcct_half

    frcct_state_t s_q;
    frcct_state_t s_d;
    logic         tick;
    logic [15:0]  count_inc;
    logic         match;
    logic         trig_edge;
    logic         rd_cnt_lo;
    logic         rd_cnt_hi;

    ////////////////////////////////////////////////////////////////////////
    // decode of events seen this cycle

    // tick when the prescaler low bits are all ones for the chosen period
    assign tick      = (s_q.presc & frcct_mask(s_q.cks)) == frcct_mask(s_q.cks);
    assign count_inc = s_q.count + 16'h0001;
    assign match     = tick && (count_inc == s_q.cmp);
    // the trigger pin is taken as synchronous, so one stage of history suffices
    always_comb
    begin
        case (s_q.edg)
            FRCCT_EDGE_RISE: trig_edge = capture_trigger_pin && !s_q.trig_prev;
            FRCCT_EDGE_FALL: trig_edge = !capture_trigger_pin && s_q.trig_prev;
            FRCCT_EDGE_BOTH: trig_edge = capture_trigger_pin != s_q.trig_prev;
            default:         trig_edge = 1'b0;
        endcase
    end
    assign rd_cnt_lo = bus_req.rd && (bus_req.addr == FRCCT_ADDR_CNT_LO);
    assign rd_cnt_hi = bus_req.rd && (bus_req.addr == FRCCT_ADDR_CNT_HI);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d           = s_q;
        s_d.trig_prev = capture_trigger_pin;
        // prescaler and counter run always; a stop release just sees the
        // count that built up while the oscillator settled
        s_d.presc = s_q.presc + 8'h01;
        if (tick)
        begin
            s_d.count = count_inc;                     // never cleared by a match
            if (s_q.count == FRCCT_CNT_MAX)
                s_d.ovf = 1'b1;
        end

        // irq pulse lasts half a count period; a rewrite of the compare
        // value behind the count only matches on the next wrap
        if (match)
        begin
            s_d.irq     = 1'b1;
            s_d.irq_cnt = frcct_half(s_q.cks);
        end
        else if (s_q.irq)
        begin
            s_d.irq_cnt = s_q.irq_cnt - 8'h01;
            if (s_q.irq_cnt == 8'h01)
                s_d.irq = 1'b0;
        end

        // capture on the selected edge, hold otherwise
        if (trig_edge)
            s_d.cap = s_q.count;

        // read buffer tracks the count unless frozen by a low-byte read
        if (!s_q.frozen)
            s_d.rbuf = s_q.count;
        if (rd_cnt_lo)
            s_d.frozen = 1'b1;
        else if (rd_cnt_hi)
            s_d.frozen = 1'b0;

        // register writes; the hardware overflow set wins over a clear
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                FRCCT_ADDR_CMP_LO: s_d.cmp[7:0]  = bus_req.wdata;
                FRCCT_ADDR_CMP_HI: s_d.cmp[15:8] = bus_req.wdata;
                FRCCT_ADDR_MODE:
                begin
                    s_d.cks = bus_req.wdata[FRCCT_MODE_CKS_LSB +: 2];
                    s_d.edg = frcct_edge_t'(bus_req.wdata[FRCCT_MODE_EDG_LSB +: 2]);
                    s_d.ovf = bus_req.wdata[FRCCT_MODE_OVF_BIT]
                              || (tick && s_q.count == FRCCT_CNT_MAX);
                end
                default: ;
            endcase
        end

        // read data, one cycle after the strobe; unmapped reads give zero
        s_d.rdata = FRCCT_RDATA_NONE;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                FRCCT_ADDR_CNT_LO: s_d.rdata = s_q.frozen ? s_q.rbuf[7:0] : s_q.count[7:0];
                FRCCT_ADDR_CNT_HI: s_d.rdata = s_q.rbuf[15:8];
                FRCCT_ADDR_CAP_LO: s_d.rdata = s_q.cap[7:0];
                FRCCT_ADDR_CAP_HI: s_d.rdata = s_q.cap[15:8];
                FRCCT_ADDR_CMP_LO: s_d.rdata = s_q.cmp[7:0];
                FRCCT_ADDR_CMP_HI: s_d.rdata = s_q.cmp[15:8];
                FRCCT_ADDR_MODE:
                begin
                    s_d.rdata[FRCCT_MODE_CKS_LSB +: 2] = s_q.cks;
                    s_d.rdata[FRCCT_MODE_EDG_LSB +: 2] = s_q.edg;
                    s_d.rdata[FRCCT_MODE_OVF_BIT]      = s_q.ovf;
                end
                default: s_d.rdata = FRCCT_RDATA_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // capture register has no defined reset value; zero keeps it clean
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q           <= '0;
            s_q.count     <= FRCCT_CNT_RST;
            s_q.rbuf      <= FRCCT_CNT_RST;
            s_q.cmp       <= FRCCT_CMP_RST;
            s_q.edg       <= FRCCT_EDGE_OFF;
            s_q.rdata     <= FRCCT_RDATA_NONE;
        end
        else
            s_q <= s_d;
    end

    assign bus_rdata         = s_q.rdata;
    assign compare_match_irq = s_q.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_count_step: assert property (tick |=> s_q.count == $past(count_inc))
        else $error("counter did not step by one on tick");
    a_match_no_clear: assert property (match |=> s_q.count == $past(s_q.cmp))
        else $error("counter disturbed by compare match");
    a_match_irq: assert property (match |=> compare_match_irq)
        else $error("match did not raise irq");
    a_irq_width4: assert property ($rose(compare_match_irq) && s_q.cks == FRCCT_CKS_DIV4
        && $stable(s_q.cks) |-> compare_match_irq ##1 compare_match_irq ##1 !compare_match_irq)
        else $error("irq width wrong at divide by four");
    // no mode write for four cycles, so the select cannot move under the check
    a_tick_period: assert property (tick && s_q.cks == FRCCT_CKS_DIV4 && !bus_req.wr ##1 !bus_req.wr [*3]
        |=> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
        else $error("count tick spacing wrong");
    a_cap_load: assert property (trig_edge |=> s_q.cap == $past(s_q.count))
        else $error("capture missed edge");
    a_cap_hold: assert property (!trig_edge |=> $stable(s_q.cap))
        else $error("capture changed without edge");
    a_cap_off: assert property (s_q.edg == FRCCT_EDGE_OFF && capture_trigger_pin != s_q.trig_prev
        |=> $stable(s_q.cap))
        else $error("capture changed while disabled");
    a_rbuf_freeze: assert property (rd_cnt_lo ##1 !rd_cnt_hi |=> $stable(s_q.rbuf))
        else $error("read buffer moved while frozen");
    a_rbuf_resume: assert property (rd_cnt_hi && !rd_cnt_lo |=> !s_q.frozen ##1 s_q.rbuf == $past(s_q.count))
        else $error("read buffer did not resume tracking");
    a_ovf_set: assert property (tick && s_q.count == FRCCT_CNT_MAX |=> s_q.ovf && s_q.count == FRCCT_CNT_RST)
        else $error("wrap did not set overflow");
    a_cmp_write: assert property (bus_req.wr && bus_req.addr == FRCCT_ADDR_CMP_HI
        |=> s_q.cmp[15:8] == $past(bus_req.wdata))
        else $error("compare high byte not written");

    c_match:   cover property (match ##1 compare_match_irq);
    c_capture: cover property (s_q.edg == FRCCT_EDGE_BOTH && trig_edge);
    c_pair:    cover property (rd_cnt_lo ##[1:4] rd_cnt_hi);
    c_wrap:    cover property (tick && s_q.count == FRCCT_CNT_MAX);

endmodule : frcct_top

// File: testbench/frcct_trig_model.sv
// frcct_trig_model: external capture trigger source facing the timer.
// assumes the bench calls set_level just after a falling mclk edge.
`timescale 1ns/1ps

module frcct_trig_model
(
    output logic capture_trigger_pin
);
    ////////////////////////////////////////////////////////////////////////
    // level only moves on request, so it holds still through capture reads
    initial capture_trigger_pin = 1'b0;

    task automatic set_level(input logic lvl);
        capture_trigger_pin = lvl;
    endtask : set_level
endmodule : frcct_trig_model

// File: testbench/frcct_top_tb.sv
// frcct_top_tb: self-checking bench for the capture/compare timer.
// assumes frcct_pkg and frcct_top are compiled; inputs move at falling mclk.
`timescale 1ns/1ps

module frcct_top_tb;
    import frcct_pkg::*;

    logic           mclk;
    logic           rst_b;
    frcct_bus_req_t bus_req;
    logic [7:0]     bus_rdata;
    logic           capture_trigger_pin;
    logic           compare_match_irq;
    int             n_mismatch;
    int             checks_done;
    int             cycles;
    int             n;
    int             w;
    logic [15:0]    cap_exp;
    logic [15:0]    cnt;
    logic [15:0]    cmp;
    logic [15:0]    rv;
    logic [7:0]     rb;

    frcct_top i_dut (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .capture_trigger_pin(capture_trigger_pin), .compare_match_irq(compare_match_irq));
    frcct_trig_model i_trig (.capture_trigger_pin(capture_trigger_pin));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock and a cycle ceiling so a stuck wait cannot hang the run
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] half_period(input int k);
        return 16'(1 << (k == 3 ? 7 : (k == 2 ? 3 : k)));
    endfunction : half_period

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one strobe cycle, then one idle cycle so strobes never merge
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        bus_req = '{addr: a, wdata: d, wr: wr, rd: !wr};
        @(negedge mclk);
        q = bus_rdata;
        bus_req = '0;
        @(negedge mclk);
    endtask : acc

    // low byte, idle gap, then high byte: counter reads always come paired
    // strobes run at mclk, never the slow-cpu case where counter reads are void
    task automatic rd_pair(input logic [15:0] a, input int gap, output logic [15:0] v);
        bus_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge mclk);
        v[7:0] = bus_rdata;
        bus_req = '0;
        repeat (gap) @(negedge mclk);
        bus_req = '{addr: a + 16'h0001, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge mclk);
        v[15:8] = bus_rdata;
        bus_req = '0;
        @(negedge mclk);
    endtask : rd_pair

    // pin edge lands on the same edge as the low counter read, so the
    // capture must equal the frozen pair even after a long gap
    task automatic cap_probe(input logic lvl, input logic hit);
        i_trig.set_level(lvl);
        rd_pair(FRCCT_ADDR_CNT_LO, $urandom_range(1, 30), cnt);
        if (hit)
            cap_exp = cnt;
        rd_pair(FRCCT_ADDR_CAP_LO, 1, rv);
        chk(rv, cap_exp);
    endtask : cap_probe

    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        bus_req = '0;
        rst_b = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        cap_exp = FRCCT_CNT_RST;
        void'($urandom(32'h9f4b));
        repeat (20) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        rd_pair(FRCCT_ADDR_CNT_LO, 1, cnt);
        chk(16'(cnt < 16'd8), 16'd1);
        rd_pair(FRCCT_ADDR_CMP_LO, 1, rv);
        chk(rv, FRCCT_CMP_RST);
        acc(1'b0, FRCCT_ADDR_MODE, 8'h00, rb);
        chk({8'h00, rb}, 16'h0000);
        // overflow flag is software writable both ways
        acc(1'b1, FRCCT_ADDR_MODE, 8'h40, rb);
        acc(1'b0, FRCCT_ADDR_MODE, 8'h00, rb);
        chk({8'h00, rb}, 16'h0040);
        acc(1'b1, FRCCT_ADDR_MODE, 8'h00, rb);
        acc(1'b0, 16'hff30, 8'h00, rb);
        chk({8'h00, rb}, {8'h00, FRCCT_RDATA_NONE});
        // every capture edge mode, rising then falling
        for (int e = 0; e < 4; e++)
        begin
            acc(1'b1, FRCCT_ADDR_MODE, 8'(e << FRCCT_MODE_EDG_LSB), rb);
            cap_probe(1'b1, e[0]);
            cap_probe(1'b0, e[1]);
        end
        // compare match at every count clock; high byte first, then low
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, FRCCT_ADDR_MODE, 8'(k << FRCCT_MODE_CKS_LSB), rb);
            rd_pair(FRCCT_ADDR_CNT_LO, 1, cnt);
            cmp = cnt + 16'($urandom_range(12, 20));
            // irq is only trusted after both bytes and a readback have landed,
            // standing in for the mask that guards a rewrite
            acc(1'b1, FRCCT_ADDR_CMP_HI, cmp[15:8], rb);
            acc(1'b1, FRCCT_ADDR_CMP_LO, cmp[7:0], rb);
            rd_pair(FRCCT_ADDR_CMP_LO, 1, rv);
            chk(rv, cmp);
            n = 0;
            while (compare_match_irq !== 1'b1 && n < 6000)
            begin
                @(negedge mclk);
                n++;
            end
            w = 0;
            while (compare_match_irq === 1'b1 && w < 300)
            begin
                @(negedge mclk);
                w++;
            end
            chk(16'(w), half_period(k));
            rd_pair(FRCCT_ADDR_CNT_LO, 1, cnt);
            chk(16'((cnt - cmp) < 16'd4), 16'd1);
        end
        // second reset in mid-run: counter and compare go back to reset values
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        rd_pair(FRCCT_ADDR_CNT_LO, 1, cnt);
        chk(16'(cnt < 16'd8), 16'd1);
        rd_pair(FRCCT_ADDR_CMP_LO, 1, rv);
        chk(rv, FRCCT_CMP_RST);
        final_report();
    end
endmodule : frcct_top_tb
